// ### rtl/block_device_mode_inquiry.sv
// mode page, inquiry data and command gating for a reduced block target
//
// How it works
// - page reads with code 06h
// - writes to fixed fields silently ignored
// - wcd picks data-received or on-medium status
// - unlockable medium forces wcd to one
// - block size and count reported
// - power level honoured after condition 07h
// - FFh max performance, 00h max saving
// - readd set forbids reading
// - writed set forbids writing
// - formatd set forbids formatting
// - writed set forces formatd set
// - lockd set blocks medium locking
// - fixed medium holds lockd at one
// - inquiry, mode select, mode sense accepted
// - test ready, buffer, sense accepted; lock only on removable medium
// - peripheral type reads 0Eh
// - rmb shows removable medium
// - aerc set and events sent when offered
// - sense rides with status when autosense
// - device error aborts every task
// - naca ignored and reported zero
// - relative addressing bit reads zero
// - linked bit reads zero
`include "bdmi_cfg.svh"
`default_nettype none
module block_device_mode_inquiry #(
    parameter bit REMOVABLE = 1'b1,
    parameter bit LOCKABLE = 1'b1,
    parameter bit AER_SUPPORT = 1'b0,
    parameter bit AUTOSENSE = 1'b1,
    parameter logic [15:0] BLOCK_SIZE = 16'h0200,
    parameter logic [39:0] BLOCK_COUNT = 40'h0000100000
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic cmd_valid,
    input wire bdmi_pkg::cmd_t cmd,
    output logic cmd_ready,
    output logic rsp_valid,
    output bdmi_pkg::rsp_t rsp,
    input wire logic wr_data_rcvd,
    input wire logic wr_media_done,
    input wire logic dev_error,
    output logic abort_all,
    output logic aer_event,
    output logic medium_locked,
    output logic perf_enable,
    output logic [7:0] perf_level
);
    // ----------------------------------------------------------------
    // mode page control word
    // ----------------------------------------------------------------
    logic wcd_q, readd_q, writed_q, formatd_q, lockd_q;
    logic [7:0] pp_q;
    logic [31:0] reg_rdata_q;
    wire wr_ctrl = reg_wr && (reg_addr == `OFS_CTRL);
    wire wcd_d = reg_wdata[`CTRL_WCD] | ~LOCKABLE;
    wire formatd_d = reg_wdata[`CTRL_FORMATD] | reg_wdata[`CTRL_WRITED];
    wire lockd_d = reg_wdata[`CTRL_LOCKD] | ~REMOVABLE;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wcd_q <= `RST_WCD;
            pp_q <= `RST_PP;
            readd_q <= 1'b0;
            writed_q <= 1'b0;
            formatd_q <= 1'b0;
            lockd_q <= ~REMOVABLE;
        end else if (wr_ctrl) begin
            wcd_q <= wcd_d;
            pp_q <= reg_wdata[`CTRL_PP_LSB +: 8];
            readd_q <= reg_wdata[`CTRL_READD];
            writed_q <= reg_wdata[`CTRL_WRITED];
            formatd_q <= formatd_d;
            lockd_q <= lockd_d;
        end
    end

    // ----------------------------------------------------------------
    // register read path
    // ----------------------------------------------------------------
    bdmi_pkg::state_t state_q, state_d;
    logic locked_q, ppen_q;
    logic [7:0] perf_q;
    wire [31:0] ctrl_word = {4'h0, readd_q, writed_q, formatd_q, lockd_q,
                             8'h00, pp_q, 7'h00, wcd_q};
    // inquiry bytes 0 to 3, naca zero
    wire [31:0] inq0_word = {AER_SUPPORT, 7'h00, 8'h00, REMOVABLE, 7'h00,
                             3'h0, `PERIPH_TYPE};
    wire [31:0] inq1_word = 32'h00000000;
    wire [31:0] stat_word = {28'h0000000, state_q == bdmi_pkg::ST_WR_WAIT,
                             ppen_q, locked_q, AUTOSENSE};
    wire [31:0] hdr_word = {16'h0000, `PAGE_LEN, 2'h2, `PAGE_CODE};
    wire [31:0] rd_mux =
        (reg_addr == `OFS_CTRL) ? ctrl_word :
        (reg_addr == `OFS_BLK_SIZE) ? {16'h0000, BLOCK_SIZE} :
        (reg_addr == `OFS_BLK_CNT_LO) ? BLOCK_COUNT[31:0] :
        (reg_addr == `OFS_BLK_CNT_HI) ? {24'h000000, BLOCK_COUNT[39:32]} :
        (reg_addr == `OFS_INQ0) ? inq0_word :
        (reg_addr == `OFS_INQ1) ? inq1_word :
        (reg_addr == `OFS_STATUS) ? stat_word :
        (reg_addr == `OFS_PAGE_HDR) ? hdr_word : 32'h00000000;

    // read data stand only in the cycle after the strobe
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata_q <= 32'h00000000;
        end else begin
            reg_rdata_q <= reg_rd ? rd_mux : 32'h00000000;
        end
    end

    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    function automatic bdmi_pkg::rsp_t mk(input logic [7:0] st,
                                          input logic [3:0] key,
                                          input logic [7:0] asc);
        bdmi_pkg::rsp_t r;
        r.status = st;
        r.sense_valid = AUTOSENSE && (st != `ST_GOOD);
        r.key = key;
        r.asc = asc;
        return r;
    endfunction

    wire [7:0] op = cmd.opcode;
    // supported opcodes; control byte, naca included, unused
    wire supported = (op == `OP_INQUIRY) || (op == `OP_MODE_SELECT) ||
                     (op == `OP_MODE_SENSE) || (op == `OP_TEST_READY) ||
                     (op == `OP_REQ_SENSE) || (op == `OP_WRITE_BUF) ||
                     (op == `OP_READ) || (op == `OP_WRITE) ||
                     (op == `OP_FORMAT) || (op == `OP_START_STOP) ||
                     (REMOVABLE && (op == `OP_MEDIUM_LOCK));
    wire refused = ((op == `OP_READ) && readd_q) ||
                   ((op == `OP_WRITE) && writed_q) ||
                   ((op == `OP_FORMAT) && formatd_q) ||
                   ((op == `OP_MEDIUM_LOCK) && cmd.arg[0] && lockd_q);
    wire wr_done = wcd_q ? wr_media_done : wr_data_rcvd;
    wire accept = cmd_valid && (state_q == bdmi_pkg::ST_IDLE);

    // ----------------------------------------------------------------
    // command sequencer
    // ----------------------------------------------------------------
    bdmi_pkg::rsp_t rsp_q, rsp_d, sense_q, sense_d;
    logic rsp_v_d, lock_d, ppen_d, abort_q, aer_q, rsp_v_q, ready_q;

    always_comb begin
        state_d = state_q;
        rsp_d = rsp_q;
        rsp_v_d = 1'b0;
        lock_d = locked_q;
        ppen_d = ppen_q;
        sense_d = sense_q;
        if (dev_error) begin
            state_d = bdmi_pkg::ST_IDLE;
            rsp_v_d = (state_q == bdmi_pkg::ST_WR_WAIT);
            rsp_d = mk(`ST_CHECK, `SK_HW_ERR, `ASC_INTERNAL);
        end else begin
            case (state_q)
                bdmi_pkg::ST_IDLE: begin
                    if (cmd_valid) begin
                        rsp_v_d = 1'b1;
                        rsp_d = mk(`ST_GOOD, `SK_NONE, `ASC_NONE);
                        if (!supported) begin
                            rsp_d = mk(`ST_CHECK, `SK_ILLEGAL, `ASC_BAD_OP);
                        end else if (refused) begin
                            rsp_d = mk(`ST_CHECK, `SK_PROTECT, `ASC_PROTECT);
                        end else if (op == `OP_WRITE) begin
                            rsp_v_d = 1'b0;
                            state_d = bdmi_pkg::ST_WR_WAIT;
                        end else if (op == `OP_START_STOP) begin
                            ppen_d = (cmd.arg[7:4] == `PC_DEVICE_CTRL);
                        end else if (op == `OP_MEDIUM_LOCK) begin
                            // lock only reached with lockd clear
                            lock_d = cmd.arg[0];
                        end else if (op == `OP_REQ_SENSE) begin
                            rsp_d = sense_q;
                            rsp_d.status = `ST_GOOD;
                            rsp_d.sense_valid = 1'b1;
                            sense_d = mk(`ST_GOOD, `SK_NONE, `ASC_NONE);
                        end
                    end
                end
                bdmi_pkg::ST_WR_WAIT: begin
                    if (wr_done) begin
                        rsp_v_d = 1'b1;
                        rsp_d = mk(`ST_GOOD, `SK_NONE, `ASC_NONE);
                        state_d = bdmi_pkg::ST_IDLE;
                    end
                end
                default: state_d = bdmi_pkg::ST_IDLE;
            endcase
        end
        // without autosense sense waits for request sense
        if (rsp_v_d && !AUTOSENSE && (rsp_d.status != `ST_GOOD)) begin
            sense_d = rsp_d;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= bdmi_pkg::ST_IDLE;
            rsp_q <= '0;
            sense_q <= '0;
            rsp_v_q <= 1'b0;
            ready_q <= 1'b0;
            locked_q <= 1'b0;
            ppen_q <= 1'b0;
            perf_q <= `PERF_DEFAULT;
            abort_q <= 1'b0;
            aer_q <= 1'b0;
        end else begin
            state_q <= state_d;
            rsp_q <= rsp_d;
            sense_q <= sense_d;
            rsp_v_q <= rsp_v_d;
            ready_q <= (state_d == bdmi_pkg::ST_IDLE);
            locked_q <= lock_d;
            ppen_q <= ppen_d;
            // level passed on unchanged, FFh when not enabled
            perf_q <= ppen_d ? pp_q : `PERF_DEFAULT;
            abort_q <= dev_error;
            // error reported as an asynchronous event
            aer_q <= dev_error && AER_SUPPORT;
        end
    end

    assign reg_rdata = reg_rdata_q;
    assign cmd_ready = ready_q;
    assign rsp_valid = rsp_v_q;
    assign rsp = rsp_q;
    assign abort_all = abort_q;
    assign aer_event = aer_q;
    assign medium_locked = locked_q;
    assign perf_enable = ppen_q;
    assign perf_level = perf_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_wr_start;
        accept && !dev_error && supported && !refused && (op == `OP_WRITE);
    endsequence

    a_page_header: assert property (
        reg_rd && (reg_addr == `OFS_PAGE_HDR) |=>
        reg_rdata[5:0] == 6'h06 && reg_rdata[15:8] == 8'h0B)
        else $error("page header wrong");
    a_fmt_implied: assert property (
        writed_q |-> formatd_q) else $error("writed without formatd");
    a_lockd_fixed: assert property (
        !REMOVABLE |-> lockd_q) else $error("lockd clear on fixed medium");
    a_wcd_forced: assert property (
        !LOCKABLE |-> wcd_q) else $error("wcd clear on unlockable");
    a_wcd_hold: assert property (
        s_wr_start ##1 (wcd_q && !wr_media_done && !dev_error)
        |=> !rsp_valid) else $error("status before medium write");
    a_cache_good: assert property (
        (state_q == bdmi_pkg::ST_WR_WAIT && !wcd_q && wr_data_rcvd &&
         !dev_error) |=> rsp_valid && rsp.status == 8'h00)
        else $error("cached write not completed");
    a_bad_opcode: assert property (
        accept && !dev_error && !supported |=>
        rsp_valid && rsp.status == 8'h02 && rsp.key == 4'h5)
        else $error("unsupported opcode not refused");
    a_read_refuse: assert property (
        accept && !dev_error && op == `OP_READ && readd_q |=>
        rsp_valid && rsp.status == 8'h02) else $error("read not refused");
    a_error_abort: assert property (
        dev_error |=> abort_all && state_q == bdmi_pkg::ST_IDLE ##1
        !abort_all || $past(dev_error)) else $error("error did not abort");
    a_lock_blocked: assert property (
        lockd_q && !medium_locked |=> !medium_locked)
        else $error("locked with lockd set");
    a_perf_gate: assert property (
        !perf_enable |-> perf_level == 8'hFF) else $error("level not gated");
    a_perf_enable: assert property (
        accept && !dev_error && op == `OP_START_STOP |=>
        perf_enable == $past(cmd.arg[7:4] == 4'h7))
        else $error("power condition not applied");
    a_perf_level: assert property (
        perf_enable |-> perf_level == $past(pp_q))
        else $error("level differs from field");
    a_write_refuse: assert property (
        accept && !dev_error && op == `OP_WRITE && writed_q |=>
        rsp_valid && rsp.status == 8'h02 && state_q == bdmi_pkg::ST_IDLE)
        else $error("write not refused");
    a_format_refuse: assert property (
        accept && !dev_error && op == `OP_FORMAT && formatd_q |=>
        rsp_valid && rsp.status == 8'h02 && rsp.key == 4'h7)
        else $error("format not refused");
    a_lock_refuse: assert property (
        accept && !dev_error && REMOVABLE && op == `OP_MEDIUM_LOCK &&
        cmd.arg[0] && lockd_q |=> rsp_valid && rsp.key == 4'h7)
        else $error("lock not refused");
    a_lock_fixed: assert property (
        accept && !dev_error && !REMOVABLE && op == `OP_MEDIUM_LOCK |=>
        rsp_valid && rsp.key == 4'h5) else $error("lock taken on fixed");
    a_mandatory_ok: assert property (
        accept && !dev_error && (op == `OP_INQUIRY ||
        op == `OP_MODE_SELECT || op == `OP_MODE_SENSE) |=>
        rsp_valid && rsp.status == 8'h00) else $error("mandatory refused");
    a_block_size: assert property (
        reg_rd && reg_addr == `OFS_BLK_SIZE |=>
        reg_rdata == {16'h0000, BLOCK_SIZE}) else $error("block size wrong");
    a_inquiry_bits: assert property (
        reg_rd && reg_addr == `OFS_INQ0 |=> reg_rdata[4:0] == 5'h0E &&
        reg_rdata[15] == REMOVABLE && !reg_rdata[29])
        else $error("inquiry fields wrong");
    a_inquiry_zero: assert property (
        reg_rd && reg_addr == `OFS_INQ1 |=> reg_rdata == 32'h00000000)
        else $error("reladr or linked set");
    a_aer_report: assert property (
        dev_error |=> aer_event == AER_SUPPORT)
        else $error("event report wrong");
    // sense rides with check only under autosense
    a_sense_auto: assert property (
        rsp_valid && rsp.status == 8'h02 |-> rsp.sense_valid == AUTOSENSE)
        else $error("sense delivery wrong");
    a_ready_idle: assert property (
        abort_all |-> cmd_ready) else $error("not ready after abort");
endmodule // block_device_mode_inquiry
`default_nettype wire

// ### rtl/bdmi_cfg.svh
// constants for the mode page and inquiry command interpreter
`ifndef BDMI_CFG_SVH
`define BDMI_CFG_SVH
// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_BLK_SIZE 8'h04
`define OFS_BLK_CNT_LO 8'h08
`define OFS_BLK_CNT_HI 8'h0C
`define OFS_INQ0 8'h10
`define OFS_INQ1 8'h14
`define OFS_STATUS 8'h18
`define OFS_PAGE_HDR 8'h1C
// control word fields
`define CTRL_WCD 0
`define CTRL_PP_LSB 8
`define CTRL_LOCKD 24
`define CTRL_FORMATD 25
`define CTRL_WRITED 26
`define CTRL_READD 27
// reset values
`define RST_WCD 1'h1
`define RST_PP 8'hFF
`define PERF_DEFAULT 8'hFF
// mode page and inquiry constants
`define PAGE_CODE 6'h06
`define PAGE_LEN 8'h0B
`define PERIPH_TYPE 5'h0E
`define PC_DEVICE_CTRL 4'h7
// opcodes
`define OP_TEST_READY 8'h00
`define OP_REQ_SENSE 8'h03
`define OP_FORMAT 8'h04
`define OP_INQUIRY 8'h12
`define OP_MODE_SELECT 8'h15
`define OP_MODE_SENSE 8'h1A
`define OP_START_STOP 8'h1B
`define OP_MEDIUM_LOCK 8'h1E
`define OP_READ 8'h28
`define OP_WRITE 8'h2A
`define OP_WRITE_BUF 8'h3B
// status, sense keys, additional sense codes
`define ST_GOOD 8'h00
`define ST_CHECK 8'h02
`define SK_NONE 4'h0
`define SK_HW_ERR 4'h4
`define SK_ILLEGAL 4'h5
`define SK_PROTECT 4'h7
`define ASC_NONE 8'h00
`define ASC_BAD_OP 8'h20
`define ASC_PROTECT 8'h27
`define ASC_INTERNAL 8'h44
`endif

// ### rtl/bdmi_pkg.sv
// types shared by the command interpreter
`default_nettype none
package bdmi_pkg;
    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] arg;
        logic [7:0] control;
    } cmd_t;
    typedef struct packed {
        logic [7:0] status;
        logic sense_valid;
        logic [3:0] key;
        logic [7:0] asc;
    } rsp_t;
    typedef enum logic {ST_IDLE, ST_WR_WAIT} state_t;
endpackage
`default_nettype wire

// ### dv/media_side_model.sv
// write data source and medium seen beside the command interpreter
`default_nettype none
module media_side_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic take_write,
    input wire logic [7:0] rcv_dly,
    input wire logic [7:0] done_dly,
    output logic wr_data_rcvd,
    output logic wr_media_done,
    output logic rcvd_seen,
    output logic done_seen
);
    timeunit 1ns;
    timeprecision 100ps;
    int cnt;
    logic busy;
    // data lands first, the medium later; both are one-cycle pulses
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt <= 0;
            busy <= 1'b0;
            wr_data_rcvd <= 1'b0;
            wr_media_done <= 1'b0;
            rcvd_seen <= 1'b0;
            done_seen <= 1'b0;
        end else begin
            cnt <= busy ? cnt + 1 : 0;
            wr_data_rcvd <= busy && cnt == int'(rcv_dly);
            wr_media_done <= busy && cnt == int'(done_dly);
            if (wr_data_rcvd) rcvd_seen <= 1'b1;
            if (wr_media_done) begin
                done_seen <= 1'b1;
                busy <= 1'b0;
            end
            if (take_write) begin
                busy <= 1'b1;
                rcvd_seen <= 1'b0;
                done_seen <= 1'b0;
            end
        end
    end
endmodule // media_side_model
`default_nettype wire

// ### dv/block_device_mode_inquiry_tb.sv
// self-checking bench for the mode page and inquiry interpreter
`default_nettype none
module block_device_mode_inquiry_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk, rst, reg_wr, reg_rd, cmd_valid, dev_error, cmd_ready;
    logic rsp_valid, wr_data_rcvd, wr_media_done, abort_all, aer_event;
    logic medium_locked, perf_enable, rcvd_seen, done_seen;
    logic [7:0] reg_addr, rcv_dly, done_dly, perf_level;
    logic [31:0] reg_wdata, reg_rdata, rx, seed, v;
    bdmi_pkg::cmd_t cmd;
    bdmi_pkg::rsp_t rsp;
    logic f_valid, f_aer;
    logic [31:0] f_rdata, rx2;
    bdmi_pkg::rsp_t f_rsp;
    int fails, checked, m_rd, m_wr, m_fmt, m_lk, m_wcd, m_pp, m_lock;
    logic [7:0] ops [12] = '{8'h00, 8'h03, 8'h04, 8'h12, 8'h15, 8'h1A,
        8'h1B, 8'h28, 8'h2A, 8'h3B, 8'h1E, 8'h35};
    logic [7:0] ra [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
        8'h18, 8'h1C, 8'h40};
    logic [31:0] rv [9] = '{32'h0000FF01, 32'h200, 32'h00100000, 32'h0,
        32'h800E, 32'h0, 32'h1, 32'h0B86, 32'h0};

    block_device_mode_inquiry DUT (.sys_clk(sys_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_valid(cmd_valid),
        .cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp),
        .wr_data_rcvd(wr_data_rcvd), .wr_media_done(wr_media_done),
        .dev_error(dev_error), .abort_all(abort_all), .aer_event(aer_event),
        .medium_locked(medium_locked), .perf_enable(perf_enable),
        .perf_level(perf_level));
    media_side_model media (.sys_clk(sys_clk), .rst(rst),
        .take_write(cmd_valid && cmd_ready && cmd.opcode == 8'h2A),
        .rcv_dly(rcv_dly), .done_dly(done_dly),
        .wr_data_rcvd(wr_data_rcvd), .wr_media_done(wr_media_done),
        .rcvd_seen(rcvd_seen), .done_seen(done_seen));
    // fixed, unlockable medium with event reporting and no autosense
    block_device_mode_inquiry #(.REMOVABLE(1'b0), .LOCKABLE(1'b0),
        .AER_SUPPORT(1'b1), .AUTOSENSE(1'b0)) fixed_dut (.sys_clk(sys_clk),
        .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(f_rdata),
        .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(), .rsp_valid(f_valid),
        .rsp(f_rsp), .wr_data_rcvd(wr_data_rcvd),
        .wr_media_done(wr_media_done), .dev_error(dev_error),
        .abort_all(), .aer_event(f_aer), .medium_locked(), .perf_enable(),
        .perf_level());

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [20:0] model(input int op, input int arg);
        int k;
        int a;
        k = 0;
        a = 0;
        if (!(op inside {0, 3, 4, 'h12, 'h15, 'h1A, 'h1B, 'h28, 'h2A, 'h3B,
            'h1E})) begin
            k = 5;
            a = 'h20;
        end else if ((op == 'h28 && m_rd != 0) || (op == 'h2A && m_wr != 0)
            || (op == 4 && m_fmt != 0)
            || (op == 'h1E && arg % 2 == 1 && m_lk != 0)) begin
            k = 7;
            a = 'h27;
        end
        // request sense hands back an empty record marked valid
        if (k == 0 && op == 3) return 21'h001000;
        return k != 0 ? {8'h02, 1'b1, 4'(k), 8'(a)} : 21'h0;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 rx = reg_rdata;
        rx2 = f_rdata;
    endtask
    task automatic send(input logic [7:0] op, input logic [7:0] arg);
        @(posedge sys_clk);
        // control byte all ones: the aca request must be ignored
        cmd <= '{op, arg, 8'hFF};
        cmd_valid <= 1'b1;
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
    endtask
    task automatic exec(input logic [7:0] op, input logic [7:0] arg);
        int i;
        send(op, arg);
        i = 0;
        #1;
        while (rsp_valid !== 1'b1 && i < 300) begin
            @(posedge sys_clk);
            #1;
            i++;
        end
        if (i == 300) begin
            fails++;
            complete_run();
        end
        chk(32'(rsp), 32'(model(op, arg)));
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        cmd_valid = 1'b0;
        cmd = '0;
        dev_error = 1'b0;
        rcv_dly = 8'h02;
        done_dly = 8'h05;
        seed = 32'h2;
        m_lock = 0;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk(perf_level, 32'hFF);
        for (int i = 0; i < 9; i++) begin
            rd(ra[i]);
            chk(rx, rv[i]);
        end
        rd(8'h10);
        chk(rx2, 32'h8000000E);
        // fixed fields take writes without complaint
        wr(8'h04, 32'hFFFF);
        rd(8'h04);
        chk(rx, 32'h200);
        for (int i = 0; i < 4; i++) begin
            v = xs() & 32'h0F00FF01;
            v[0] = i[0];
            v[26] = i[1];
            rcv_dly <= 8'(1 + xs() % 4);
            done_dly <= 8'(6 + xs() % 8);
            wr(8'h00, v);
            m_wcd = int'(v[0]);
            m_pp = int'(v[15:8]);
            m_rd = int'(v[27]);
            m_wr = int'(v[26]);
            m_fmt = int'(v[25] | v[26]);
            m_lk = int'(v[24]);
            rd(8'h00);
            chk(rx, 32'((m_rd << 27) | (m_wr << 26) | (m_fmt << 25)
                | (m_lk << 24) | (m_pp << 8) | m_wcd));
            chk(rx2, 32'((m_rd << 27) | (m_wr << 26) | (m_fmt << 25)
                | (1 << 24) | (m_pp << 8) | 1));
            foreach (ops[j]) begin
                exec(ops[j], 8'h71);
                if (ops[j] == 8'h2A && m_wr == 0) begin
                    chk({rcvd_seen, done_seen}, m_wcd != 0 ? 2'b11 : 2'b10);
                end
                if (ops[j] == 8'h1E && m_lk == 0) m_lock = 1;
            end
            chk(medium_locked, 32'(m_lock));
            chk({perf_enable, perf_level}, 32'h100 | m_pp);
        end
        exec(8'h1E, 8'h00);
        chk(medium_locked, 32'h0);
        exec(8'h1B, 8'h10);
        chk({perf_enable, perf_level}, 32'h0FF);
        // a device error drops the pending write at once
        wr(8'h00, 32'h1);
        rcv_dly <= 8'hC8;
        done_dly <= 8'hC8;
        send(8'h2A, 8'h00);
        @(posedge sys_clk);
        dev_error <= 1'b1;
        @(posedge sys_clk);
        dev_error <= 1'b0;
        #1;
        chk({abort_all, rsp_valid, rsp}, {9'h0, 2'b11, 21'h005444});
        chk(aer_event, 32'h0);
        chk({f_aer, f_valid, f_rsp}, {9'h0, 2'b11, 21'h004444});
        @(posedge sys_clk);
        #1;
        chk(cmd_ready, 32'h1);
        // without autosense the stored record comes back on request
        exec(8'h03, 8'h00);
        chk(f_rsp, 32'h001444);
        complete_run();
    end
endmodule // block_device_mode_inquiry_tb
`default_nettype wire
